// ==== swst_defines.svh ====
// Contract
// R1 - Master starts every slot by pulling the line low; that edge times the slave.
// R2 - Master keeps each slot between 60 us and under 120 us.
// R3 - Write one: master holds low 1 to under 15 us, then releases.
// R4 - Write zero: master holds low at least 60 us, at most 120 us.
// R5 - Master leaves at least 1 us released recovery between slots.
// R6 - Read slot: master drives low 1 to under 15 us, then releases.
// R7 - Slave returning zero holds low through valid window, releases under 45 us later.
// R8 - Slave read data valid within 1 us of edge, held until 15 us.
// R9 - Master samples read data late but inside the 15 us window.
// R10 - Master keeps initiating low pulses at least 1 us, short as practical.
// R11 - Master holds reset low 480 us, not beyond 960 us.
// R12 - Master keeps line high 480 us after reset before anything else.
// R13 - After reset rising edge slave waits 15-60 us, then presence low 60-240 us.
// R14 - Timekeeping oscillator comes up stopped until enabled over the bus.
// R15 - Line low over 120 us resets the slave's bus interface.
// R16 - Slave samples write slot once, 15-60 us after edge; high is one.
// R17 - Slot timing counts own clock from the falling edge, covering 960 us.
`ifndef SWST_DEFINES_SVH
`define SWST_DEFINES_SVH
`define SWST_CLK_MHZ 200
`define SWST_RATE_NS 6
`define SWST_RESET_DETECT_US 120
`define SWST_WRITE_SAMPLE_US 30
`define SWST_READ_HOLD_US 15
`define SWST_READ_RELEASE_US 30
`define SWST_PRESENCE_WAIT_US 30
`define SWST_PRESENCE_LOW_US 120
`define SWST_MAX_US 960
`define SWST_CNT_W 18
`endif

// ==== swst_pkg.sv ====
package swst_pkg;
   typedef enum logic [4:0] {
      SWST_IDLE = 5'h01,
      SWST_LOW = 5'h02,
      SWST_WAIT_HIGH = 5'h04,
      SWST_PRES_WAIT = 5'h08,
      SWST_PRES_LOW = 5'h10
   } swst_state_t;
   typedef struct packed {
      logic tx_bit;
      logic tx_valid;
   } swst_tx_t;
   typedef struct packed {
      logic rx_bit;
      logic rx_valid;
      logic bus_reset;
   } swst_rx_t;
endpackage

// ==== swst_slot_engine.sv ====
`timescale 1ns/1ps
`include "swst_defines.svh"
// Slot engine of the slave. All bus timing runs on the link clock so the line is
// observed in its own domain; bit events cross to ref_clk by toggle handshakes.
// The link clock is assumed free running, since presence and reset timing
// proceed while the line is idle.
// A bit for a read slot must be offered well before the master's falling edge.
// The offer needs a few link clocks to cross, so a bit that arrives later than
// that is not driven in the current slot; it is kept for the following slot only
// if it is a zero and that slot ends before 30 us, otherwise it is dropped.
// Slot intervals are counted in link clocks from the synchronised falling edge, the presence wait from the rising edge.
// The synchroniser adds two link clocks of delay to every edge, which is tiny
// against the microsecond windows of the bus, so no correction is applied.
module swst_slot_engine #(
   parameter int LINK_MHZ = 166,
   parameter int CNT_W = `SWST_CNT_W
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic link_clk,
   input wire logic line_in,
   output logic line_out,
   output logic line_oe,
   input wire swst_pkg::swst_tx_t tx,
   output logic tx_ready,
   output swst_pkg::swst_rx_t rx,
   input wire logic osc_enable_set,
   output logic osc_running
);
   import swst_pkg::*;

   localparam logic [CNT_W-1:0] RST_CYC = CNT_W'(`SWST_RESET_DETECT_US * LINK_MHZ);
   localparam logic [CNT_W-1:0] WS_CYC = CNT_W'(`SWST_WRITE_SAMPLE_US * LINK_MHZ);
   localparam logic [CNT_W-1:0] RH_CYC = CNT_W'(`SWST_READ_HOLD_US * LINK_MHZ);
   localparam logic [CNT_W-1:0] RR_CYC = CNT_W'(`SWST_READ_RELEASE_US * LINK_MHZ);
   localparam logic [CNT_W-1:0] PW_CYC = CNT_W'(`SWST_PRESENCE_WAIT_US * LINK_MHZ);
   localparam logic [CNT_W-1:0] PL_CYC = CNT_W'(`SWST_PRESENCE_LOW_US * LINK_MHZ);

   // The write sample sits at 30 us, in the middle of the allowed range.
   // A one bit has then had ample time to rise through the pull-up, while a
   // zero bit from the slowest legal master is still held low.
   // The read-zero release also sits at 30 us: well past the end of the
   // valid window, and well inside the allowed release time after it.
   // The presence wait and the presence pulse sit in the middle of their
   // ranges, so that master and slave clock tolerances both have room.
   // The counter saturates at all ones, so a line stuck low cannot wrap it
   // back into a slot window and fake a second reset detection.

   // Link-domain state.
   typedef struct packed {
      swst_state_t st;
      logic [CNT_W-1:0] cnt;
      // Two synchroniser stages, plus one stage that remembers the last level.
      logic [2:0] sync;
      logic drive;
      logic sampled;
      logic rd_bit;
      logic rd_have;
      logic [2:0] tx_sync;
      logic rx_tgl;
      logic rx_bit;
      logic rst_tgl;
      logic tx_ack_tgl;
   } swst_link_t;

   // Reference-domain state.
   typedef struct packed {
      logic tx_tgl;
      logic tx_bit;
      logic busy;
      logic [2:0] rx_sync;
      logic [2:0] rst_sync;
      logic [2:0] ack_sync;
      logic rx_bit;
      logic rx_valid;
      logic bus_reset;
      logic osc;
   } swst_ref_t;

   swst_link_t l_reg, l_next;
   swst_ref_t r_reg, r_next;

   always_comb begin
      logic line;
      logic fall;
      l_next = l_reg;
      line = l_reg.sync[1];
      l_next.sync = {l_reg.sync[1:0], line_in};
      l_next.tx_sync = {l_reg.tx_sync[1:0], r_reg.tx_tgl};
      // The edge is taken from the settled stage and its delayed copy only.
      // Reading the first stage would let a metastable level reach the FSM.
      fall = l_reg.sync[2] & ~l_reg.sync[1];
      if (l_reg.tx_sync[2] != l_reg.tx_sync[1]) begin
         l_next.rd_bit = r_reg.tx_bit;
         l_next.rd_have = 1'b1;
         l_next.tx_ack_tgl = ~l_reg.tx_ack_tgl;
      end
      if (l_reg.cnt != {CNT_W{1'b1}}) begin
         l_next.cnt = l_reg.cnt + 1'b1; // see R17
      end
      case (l_reg.st)
         SWST_IDLE: begin
            if (fall) begin
               l_next.st = SWST_LOW; // see R1
               l_next.cnt = '0;
               l_next.sampled = 1'b0;
               if (l_reg.rd_have && !l_reg.rd_bit) begin
                  l_next.drive = 1'b1; // see R8
               end
            end
         end
         SWST_LOW: begin
            if (l_reg.rd_have && !l_reg.rd_bit) begin
               if (l_reg.cnt >= RR_CYC) begin
                  l_next.drive = 1'b0; // see R7
               end
            end else if (!l_reg.sampled && l_reg.cnt == WS_CYC) begin
               l_next.sampled = 1'b1; // see R16
               l_next.rx_bit = line;
               l_next.rx_tgl = ~l_reg.rx_tgl;
            end
            if (l_reg.cnt >= RH_CYC && l_reg.rd_have && l_reg.cnt == RR_CYC) begin
               l_next.rd_have = 1'b0;
            end
            if (!line && !l_reg.drive && l_reg.cnt >= RST_CYC) begin
               l_next.st = SWST_WAIT_HIGH; // see R15
               l_next.rd_have = 1'b0;
               l_next.rst_tgl = ~l_reg.rst_tgl;
            end else if (line && !l_reg.drive && l_reg.cnt > RH_CYC &&
                         (l_reg.sampled || l_reg.rd_have || l_reg.cnt > WS_CYC)) begin
               // A write slot stays here until its sample is taken, since a
               // one bit releases the line long before the sample point.
               l_next.st = SWST_IDLE;
               l_next.rd_have = l_reg.rd_have & l_reg.cnt < RR_CYC;
               if (l_reg.rd_have && l_reg.rd_bit) begin
                  l_next.rd_have = 1'b0;
               end
            end
         end
         SWST_WAIT_HIGH: begin
            if (line) begin
               l_next.st = SWST_PRES_WAIT;
               l_next.cnt = '0;
            end
         end
         SWST_PRES_WAIT: begin
            if (l_reg.cnt >= PW_CYC) begin
               l_next.st = SWST_PRES_LOW; // see R13
               l_next.drive = 1'b1;
               l_next.cnt = '0;
            end
         end
         SWST_PRES_LOW: begin
            if (l_reg.cnt >= PL_CYC) begin
               l_next.st = SWST_IDLE; // see R13
               l_next.drive = 1'b0;
            end
         end
         default: begin
            l_next.st = SWST_IDLE;
            l_next.drive = 1'b0;
         end
      endcase
   end

   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) begin
         // The line idles high, so the synchroniser starts high as well and
         // no false falling edge follows reset.
         l_reg <= '{st: SWST_IDLE, sync: 3'h7, default: '0};
      end else begin
         l_reg <= l_next;
      end
   end

   // Reference-domain side of the toggle handshakes. Each toggle passes two
   // flip-flops before it is compared, and the data that goes with it has been
   // stable for several link clocks by then, so it may be read directly.
   always_comb begin
      r_next = r_reg;
      r_next.rx_sync = {r_reg.rx_sync[1:0], l_reg.rx_tgl};
      r_next.rst_sync = {r_reg.rst_sync[1:0], l_reg.rst_tgl};
      r_next.ack_sync = {r_reg.ack_sync[1:0], l_reg.tx_ack_tgl};
      r_next.rx_valid = r_reg.rx_sync[2] != r_reg.rx_sync[1];
      r_next.bus_reset = r_reg.rst_sync[2] != r_reg.rst_sync[1];
      if (r_reg.rx_sync[2] != r_reg.rx_sync[1]) begin
         r_next.rx_bit = l_reg.rx_bit;
      end
      if (r_reg.ack_sync[2] != r_reg.ack_sync[1]) begin
         r_next.busy = 1'b0;
      end
      if (tx.tx_valid && !r_reg.busy) begin
         r_next.tx_bit = tx.tx_bit;
         r_next.tx_tgl = ~r_reg.tx_tgl;
         r_next.busy = 1'b1;
      end
      if (osc_enable_set) begin
         r_next.osc = 1'b1; // see R14
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         r_reg <= '0; // see R14
      end else begin
         r_reg <= r_next;
      end
   end

   assign line_out = 1'b0;
   assign line_oe = l_reg.drive;
   assign tx_ready = ~r_reg.busy;
   assign rx = '{rx_bit: r_reg.rx_bit, rx_valid: r_reg.rx_valid, bus_reset: r_reg.bus_reset};
   assign osc_running = r_reg.osc;
endmodule

// ==== swst_slot_engine_monitor.sv ====
`timescale 1ns/1ps
module swst_slot_engine_monitor #(parameter int LINK_MHZ = 166) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic link_clk,
   input wire logic line_out,
   input wire logic line_oe,
   input wire swst_pkg::swst_rx_t rx,
   input wire logic osc_enable_set,
   input wire logic osc_running
);
   localparam int MIN_OE = 14 * LINK_MHZ;
   localparam int MAX_OE = 240 * LINK_MHZ;
   logic [17:0] oe_len_reg;
   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) oe_len_reg <= '0;
      else oe_len_reg <= line_oe ? oe_len_reg + 18'h1 : '0;
   end
   oe_span_a: assert property (@(posedge link_clk) disable iff (!resetn)
      $fell(line_oe) |-> $past(oe_len_reg) >= MIN_OE && $past(oe_len_reg) < MAX_OE)
      else $error("slave low pulse length out of range");
   oe_bound_a: assert property (@(posedge link_clk) disable iff (!resetn)
      oe_len_reg < MAX_OE) else $error("slave holds the line low too long");
   pull_only_a: assert property (@(posedge link_clk) disable iff (!resetn)
      line_out == 1'b0) else $error("slave drives the line high");
   osc_off_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      !osc_enable_set && !osc_running |=> !osc_running) else $error("oscillator started alone");
   bit_pulse_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      rx.rx_valid |=> !rx.rx_valid) else $error("bit strobe longer than one cycle");
   reset_pulse_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      rx.bus_reset |=> !rx.bus_reset) else $error("bus reset strobe too long");
endmodule
bind swst_slot_engine swst_slot_engine_monitor #(.LINK_MHZ(LINK_MHZ)) u_mon (.*);

// ==== swst_host_model.sv ====
`timescale 1ns/1ps
// Bus master stand-in; one microsecond is US link clocks. It only pulls low.
module swst_host_model #(parameter int US = 4) (
   input wire logic link_clk,
   input wire logic line,
   output logic m_low
);
   initial m_low = 1'b0;
   // Slot of 70 us plus 2 us recovery; sampling at 13 us sits late in the valid window.
   task automatic slot(input int low_us, output logic s13, output logic s60);
      for (int c = 0; c < 72 * US; c++) begin
         m_low <= c < low_us * US;
         if (c == 13 * US) s13 = line;
         if (c == 60 * US) s60 = line;
         @(posedge link_clk);
      end
   endtask
   task automatic rst(output int wait_cnt, output int low_cnt);
      wait_cnt = 0;
      low_cnt = 0;
      for (int c = 0; c < 1440 * US; c++) begin
         m_low <= c < 480 * US;
         if (c > 480 * US && !line) low_cnt++;
         else if (c > 480 * US && low_cnt == 0) wait_cnt++;
         @(posedge link_clk);
      end
   endtask
endmodule

// ==== single_wire_slot_timing_bench.sv ====
`timescale 1ns/1ps
module single_wire_slot_timing_bench;
   import swst_pkg::*;
   localparam int US = 4;
   logic ref_clk = 1'b0;
   logic link_clk = 1'b0;
   logic resetn = 1'b0;
   logic osc_enable_set = 1'b0;
   logic line_out, line_oe, tx_ready, osc_running, m_low, s13, s60, got;
   swst_tx_t tx = '0;
   swst_rx_t rx;
   int mismatches = 0, samples_checked = 0, n_rx = 0, n_rst = 0, a, b;
   wire line_in = !(m_low || line_oe);
   always #2.5 ref_clk = !ref_clk;
   always #3 link_clk = !link_clk;
   always @(negedge ref_clk) begin
      if (rx.rx_valid === 1'b1) n_rx++;
      if (rx.rx_valid === 1'b1) got = rx.rx_bit;
      if (rx.bus_reset === 1'b1) n_rst++;
   end
   swst_slot_engine #(.LINK_MHZ(US)) u_dut (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .link_clk(link_clk),
      .line_in(line_in),
      .line_out(line_out),
      .line_oe(line_oe),
      .tx(tx),
      .tx_ready(tx_ready),
      .rx(rx),
      .osc_enable_set(osc_enable_set),
      .osc_running(osc_running)
   );
   swst_host_model #(.US(US)) u_host (.link_clk(link_clk), .line(line_in), .m_low(m_low));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic offer(input logic v);
      int i;
      i = 0;
      @(negedge ref_clk) tx <= '{v, 1'b1};
      while (tx_ready !== 1'b1 && i < 99) @(negedge ref_clk) i++;
      if (i == 99) begin
         mismatches++;
         final_report();
      end
      @(negedge ref_clk) tx <= '0;
   endtask
   task automatic t_osc();
      chk("osc off", osc_running, 1'b0);
      @(negedge ref_clk) osc_enable_set <= 1'b1;
      @(negedge ref_clk) osc_enable_set <= 1'b0;
      repeat (4) @(negedge ref_clk);
      chk("osc on", osc_running, 1'b1);
   endtask
   // A bit queued before the reset must be dropped, so the next slot is a write.
   task automatic t_reset();
      offer(1'b0);
      u_host.rst(a, b);
      chk("presence wait", a >= 15 * US && a <= 60 * US, 1'b1);
      chk("presence low", b >= 60 * US && b <= 240 * US, 1'b1);
      chk("bus reset", n_rst, 1);
   endtask
   task automatic t_write(input logic v);
      int n;
      n = n_rx;
      u_host.slot(v ? 2 : 65, s13, s60);
      chk("line in write", s13, v);
      chk("written bit", got, v);
      chk("bit count", n_rx, n + 1);
   endtask
   task automatic t_read(input logic v);
      offer(v);
      repeat (6) @(posedge link_clk);
      u_host.slot(2, s13, s60);
      chk("read bit", s13, v);
      chk("ready again", tx_ready, 1'b1);
      chk("released", s60, 1'b1);
   endtask
   initial begin
      repeat (3) @(negedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(negedge ref_clk);
      t_osc();
      t_reset();
      t_write(1'b1);
      t_write(1'b0);
      t_read(1'b0);
      t_read(1'b1);
      t_read(1'b0);
      final_report();
   end
endmodule
